// ---- hdl/fbc_host_ctrl.v ----
// Host-side controller driving an asynchronous parallel flash over its pins
`timescale 1ns/1ns
`include "fbc_map.vh"
module fbc_host_ctrl #(
  parameter ADDR_W         = 22,
  parameter TW             = 12,
  parameter RST_PULSE_CYC  = `FBC_CYC(`FBC_T_RST_PULSE),
  parameter WAKE_DATA_CYC  = `FBC_CYC(`FBC_T_WAKE_DATA),
  parameter WAKE_WRITE_CYC = `FBC_CYC(`FBC_T_WAKE_WRITE),
  parameter RD_ACC_CYC     = `FBC_CYC(`FBC_T_RD_ACC),
  parameter WE_LOW_CYC     = `FBC_CYC(`FBC_T_WE_LOW),
  parameter SETUP_CYC      = `FBC_CYC(`FBC_T_SETUP),
  parameter HOLD_CYC       = `FBC_CYC(`FBC_T_HOLD)
) (
  // Clock, reset, enable
  input  wire              ref_clk,
  input  wire              srst,
  input  wire              clk_en,
  // APB slave
  input  wire [7:0]        paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Flash control pins
  output reg               chip_sel_a_n,
  output reg               chip_sel_b_n,
  output reg               oe_n,
  output reg               we_n,
  output reg               reset_powerdown_n,
  output reg               byte_wide_sel,
  output reg  [ADDR_W-1:0] flash_addr,
  // Flash data pins, low and high byte lanes
  input  wire [15:0]       dq_i,
  output reg  [15:0]       dq_o,
  output reg  [1:0]        dq_oe,
  // Flash status pin
  input  wire              status_pin
);
  localparam [2:0] S_IDLE     = 3'h0;
  localparam [2:0] S_RST_LOW  = 3'h1;
  localparam [2:0] S_PD       = 3'h2;
  localparam [2:0] S_RD_ADDR  = 3'h3;
  localparam [2:0] S_RD_OE    = 3'h4;
  localparam [2:0] S_WR_ADDR  = 3'h5;
  localparam [2:0] S_WR_PULSE = 3'h6;
  localparam [2:0] S_WR_REL   = 3'h7;

  localparam          RDACC_N = RD_ACC_CYC + `FBC_SYNC_CYC;
  localparam [TW-1:0] C_RST   = RST_PULSE_CYC[TW-1:0];
  localparam [TW-1:0] C_WAKED = WAKE_DATA_CYC[TW-1:0];
  localparam [TW-1:0] C_WAKEW = WAKE_WRITE_CYC[TW-1:0];
  localparam [TW-1:0] C_RDACC = RDACC_N[TW-1:0];
  localparam [TW-1:0] C_WELOW = WE_LOW_CYC[TW-1:0];
  localparam [TW-1:0] C_SETUP = SETUP_CYC[TW-1:0];
  localparam [TW-1:0] C_HOLD  = HOLD_CYC[TW-1:0];

  reg [2:0]        state_q;
  reg [1:0]        op_q;
  reg              wide_q;
  reg              pd_hold_q;
  reg              go_q;
  reg              done_q;
  reg [ADDR_W-1:0] addr_q;
  reg [15:0]       wdata_q;
  reg [15:0]       rdata_q;
  reg [TW-1:0]     wake_q;
  reg              tmr_load;
  reg [TW-1:0]     tmr_count;
  reg [31:0]       rd_mux;
  reg              rd_err;
  wire             tmr_done;
  wire [16:0]      pins_s;
  wire [15:0]      dq_s;
  wire             ready_s;
  wire             rd_ok;
  wire             wr_ok;
  wire             acc_wr;
  wire             go_set;
  wire             go_take;
  wire             op_end;
  wire             rst_enter;

  // Pin inputs cross into the clock domain first
  fbc_sync #(
    .W (17)
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .din     ({status_pin, dq_i}),
    .dout    (pins_s)
  );
  assign dq_s    = pins_s[15:0];
  assign ready_s = pins_s[16];

  fbc_timer #(
    .W (TW)
  ) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .load    (tmr_load),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  assign rd_ok   = (wake_q >= C_WAKED);
  assign wr_ok   = (wake_q >= C_WAKEW);
  assign acc_wr  = psel & penable & pready & pwrite;
  assign go_set  = acc_wr & (paddr == `FBC_REG_CTRL) & pwdata[`FBC_CTRL_GO];
  assign go_take = (state_q == S_IDLE) & go_q & ~pd_hold_q &
                   ((op_q == `FBC_OP_RESET) |
                    ((op_q == `FBC_OP_READ) & rd_ok) |
                    ((op_q == `FBC_OP_WRITE) & wr_ok));
  assign op_end  = tmr_done & ((state_q == S_RD_OE) | (state_q == S_WR_REL) |
                   ((state_q == S_RST_LOW) & ~pd_hold_q));
  // Pin still low from srst gets a full timed pulse, however short srst was
  assign rst_enter = pd_hold_q | ~reset_powerdown_n | (go_take & (op_q == `FBC_OP_RESET));

  // Register read mux
  always @* begin
    rd_mux = `FBC_ZERO32;
    rd_err = 1'b0;
    if (paddr == `FBC_REG_CTRL) begin
      rd_mux[`FBC_CTRL_GO]                    = go_q;
      rd_mux[`FBC_CTRL_OP_HI:`FBC_CTRL_OP_LO] = op_q;
      rd_mux[`FBC_CTRL_WIDE]                  = wide_q;
      rd_mux[`FBC_CTRL_PDHOLD]                = pd_hold_q;
    end else if (paddr == `FBC_REG_ADDR) begin
      rd_mux[ADDR_W-1:0] = addr_q;
    end else if (paddr == `FBC_REG_WDATA) begin
      rd_mux[15:0] = wdata_q;
    end else if (paddr == `FBC_REG_RDATA) begin
      rd_mux[15:0] = rdata_q;
    end else if (paddr == `FBC_REG_STATUS) begin
      rd_mux[`FBC_ST_BUSY]  = (state_q != S_IDLE) | go_q;
      rd_mux[`FBC_ST_READY] = ready_s;
      rd_mux[`FBC_ST_DONE]  = done_q;
      rd_mux[`FBC_ST_PD]    = ~reset_powerdown_n;
      rd_mux[`FBC_ST_RD_OK] = rd_ok;
      rd_mux[`FBC_ST_WR_OK] = wr_ok;
    end else begin
      rd_err = 1'b1;
    end
  end

  // APB slave: one access cycle, answer registered in setup
  always @(posedge ref_clk) begin
    if (srst) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= `FBC_ZERO32;
      op_q      <= `FBC_OP_READ;
      wide_q    <= 1'b1;
      pd_hold_q <= 1'b0;
      addr_q    <= {ADDR_W{1'b0}};
      wdata_q   <= 16'h0000;
      go_q      <= 1'b0;
      done_q    <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & rd_err;
      if (psel & ~penable & ~pready) begin
        prdata <= pwrite ? `FBC_ZERO32 : rd_mux;
      end
      if (acc_wr) begin
        if (paddr == `FBC_REG_CTRL) begin
          op_q      <= pwdata[`FBC_CTRL_OP_HI:`FBC_CTRL_OP_LO];
          wide_q    <= pwdata[`FBC_CTRL_WIDE];
          pd_hold_q <= pwdata[`FBC_CTRL_PDHOLD];
        end else if (paddr == `FBC_REG_ADDR) begin
          addr_q <= pwdata[ADDR_W-1:0];
        end else if (paddr == `FBC_REG_WDATA) begin
          wdata_q <= pwdata[15:0];
        end
      end
      // Software sets the request, the sequencer clears; set wins
      if (go_set) begin
        go_q <= 1'b1;
      end else if (go_take) begin
        go_q <= 1'b0;
      end
      // Sequencer sets done, software clears by writing one; set wins
      if (op_end) begin
        done_q <= 1'b1;
      end else if (acc_wr & (paddr == `FBC_REG_STATUS) & pwdata[`FBC_ST_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // Cycles since reset release, saturating
  always @(posedge ref_clk) begin
    if (srst) begin
      wake_q <= {TW{1'b0}};
    end else if (clk_en) begin
      if (!reset_powerdown_n) begin
        wake_q <= {TW{1'b0}};
      end else if (wake_q != {TW{1'b1}}) begin
        wake_q <= wake_q + {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Timer loads on the edge that enters a timed phase
  always @* begin
    tmr_load  = 1'b0;
    tmr_count = C_SETUP;
    case (state_q)
      S_IDLE: begin
        if (rst_enter) begin
          tmr_load  = 1'b1;
          tmr_count = C_RST;
        end else if (go_take) begin
          tmr_load  = 1'b1;
          tmr_count = C_SETUP;
        end
      end
      S_RD_ADDR: begin
        tmr_load  = tmr_done;
        tmr_count = C_RDACC;
      end
      S_WR_ADDR: begin
        tmr_load  = tmr_done;
        tmr_count = C_WELOW;
      end
      S_WR_PULSE: begin
        tmr_load  = tmr_done;
        tmr_count = C_HOLD;
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = C_SETUP;
      end
    endcase
  end

  // Pin sequencer
  always @(posedge ref_clk) begin
    if (srst) begin
      // Flash held in reset for as long as the system is; idle restarts the pulse
      state_q           <= S_IDLE;
      reset_powerdown_n <= 1'b0;
      chip_sel_a_n      <= 1'b1;
      chip_sel_b_n      <= 1'b1;
      oe_n              <= 1'b1;
      we_n              <= 1'b1;
      byte_wide_sel     <= 1'b1;
      flash_addr        <= {ADDR_W{1'b0}};
      dq_o              <= 16'h0000;
      dq_oe             <= 2'b00;
      rdata_q           <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        S_IDLE: begin
          byte_wide_sel <= wide_q;
          if (rst_enter) begin
            // Aborts any running alteration inside the flash
            reset_powerdown_n <= 1'b0;
            state_q           <= S_RST_LOW;
          end else if (go_take) begin
            flash_addr   <= addr_q;
            chip_sel_a_n <= 1'b0;
            chip_sel_b_n <= 1'b0;
            if (op_q == `FBC_OP_WRITE) begin
              dq_o    <= wdata_q;
              dq_oe   <= {wide_q, 1'b1};
              state_q <= S_WR_ADDR;
            end else begin
              state_q <= S_RD_ADDR;
            end
          end
        end
        S_RST_LOW: begin
          // Minimum low pulse before leaving
          if (tmr_done) begin
            if (pd_hold_q) begin
              state_q <= S_PD;
            end else begin
              reset_powerdown_n <= 1'b1;
              state_q           <= S_IDLE;
            end
          end
        end
        S_PD: begin
          if (!pd_hold_q) begin
            reset_powerdown_n <= 1'b1;
            state_q           <= S_IDLE;
          end
        end
        S_RD_ADDR: begin
          if (tmr_done) begin
            // Write enable and reset already high here
            oe_n    <= 1'b0;
            state_q <= S_RD_OE;
          end
        end
        S_RD_OE: begin
          // Access time plus the synchroniser delay before sampling
          if (tmr_done) begin
            rdata_q      <= {dq_s[15:8] & {8{wide_q}}, dq_s[7:0]};
            oe_n         <= 1'b1;
            chip_sel_a_n <= 1'b1;
            chip_sel_b_n <= 1'b1;
            state_q      <= S_IDLE;
          end
        end
        S_WR_ADDR: begin
          // Output enable stays high through the whole write
          if (tmr_done) begin
            we_n    <= 1'b0;
            state_q <= S_WR_PULSE;
          end
        end
        S_WR_PULSE: begin
          // Write enable rises first, so it is the capturing edge
          if (tmr_done) begin
            we_n    <= 1'b1;
            state_q <= S_WR_REL;
          end
        end
        S_WR_REL: begin
          // Data and selects held past the capture edge
          if (tmr_done) begin
            chip_sel_a_n <= 1'b1;
            chip_sel_b_n <= 1'b1;
            dq_oe        <= 2'b00;
            state_q      <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- hdl/fbc_sync.v ----
// Two-flop synchroniser for pin inputs, one per bit
`timescale 1ns/1ns
module fbc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         srst,
  input  wire         clk_en,
  // Data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge ref_clk) begin
        if (srst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (clk_en) begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule

// ---- hdl/fbc_timer.v ----
// Loadable down-counter that times pin phases
`timescale 1ns/1ns
module fbc_timer #(
  parameter W = 12
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         srst,
  input  wire         clk_en,
  // Control
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         done
);
  reg [W-1:0] cnt_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= {W{1'b0}};
    end else if (clk_en) begin
      if (load) begin
        cnt_q <= count;
      end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done = (cnt_q == {W{1'b0}});
endmodule

// ---- include/fbc_map.vh ----
// Register map, field layout and timing constants of the flash bus controller
`ifndef FBC_MAP_VH
`define FBC_MAP_VH

// APB register offsets (byte addresses)
`define FBC_REG_CTRL      8'h00
`define FBC_REG_ADDR      8'h04
`define FBC_REG_WDATA     8'h08
`define FBC_REG_RDATA     8'h0c
`define FBC_REG_STATUS    8'h10

// Control register fields
`define FBC_CTRL_GO       0
`define FBC_CTRL_OP_LO    1
`define FBC_CTRL_OP_HI    2
`define FBC_CTRL_WIDE     3
`define FBC_CTRL_PDHOLD   4

// Status register fields
`define FBC_ST_BUSY       0
`define FBC_ST_READY      1
`define FBC_ST_DONE       2
`define FBC_ST_PD         3
`define FBC_ST_RD_OK      4
`define FBC_ST_WR_OK      5

// Operation codes
`define FBC_OP_READ       2'h0
`define FBC_OP_WRITE      2'h1
`define FBC_OP_RESET      2'h2

// Reset values
`define FBC_CTRL_RST      5'h08
`define FBC_ZERO32        32'h0000_0000

// Timing in ns, clock period in ns, synchroniser delay in cycles
`define FBC_CLK_NS        20
`define FBC_T_RST_PULSE   100
`define FBC_T_WAKE_DATA   1000
`define FBC_T_WAKE_WRITE  1000
`define FBC_T_RD_ACC      120
`define FBC_T_WE_LOW      60
`define FBC_T_SETUP       20
`define FBC_T_HOLD        20
`define FBC_SYNC_CYC      2

// Least time to cycles, rounded up
`define FBC_CYC(ns) (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

// ---- verif/fbc_flash_mdl.sv ----
// Behavioural flash device at the controller's pins
`timescale 1ns/1ns
module fbc_flash_mdl #(
  parameter [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter [15:0] PART_CODE  = 16'h005c, // Arbitrary value
  parameter        BUSY_NS    = 1000,
  // Programming supply below lockout: reads only
  parameter        SUPPLY_LOW = 0
) (
  // Control pins
  input  wire        chip_sel_a_n,
  input  wire        chip_sel_b_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        reset_powerdown_n,
  input  wire        byte_wide_sel,
  input  wire [21:0] flash_addr,
  // Data and status pins
  input  wire [15:0] dq_o,
  input  wire [1:0]  dq_oe,
  output wire [15:0] dq_i,
  output wire        status_pin
);
  reg  [15:0] mem [0:15];
  reg  [15:0] rd;
  reg  [7:0]  pend_q = 8'h00;
  reg  [1:0]  mode_q = 2'h0;
  reg  [1:0]  lock_q = 2'h0;
  reg         wr_act = 1'b0;
  reg         busy   = 1'b0;
  reg         abort  = 1'b0;
  integer     i;
  wire [3:0]  wa  = flash_addr[3:0];
  wire [14:0] off = flash_addr[14:0];
  wire        sel = !chip_sel_a_n && !chip_sel_b_n && reset_powerdown_n;
  wire        drv = sel && !oe_n;
  wire [15:0] din = dq_o & (byte_wide_sel ? 16'hffff : 16'h00ff);
  // Floating lines show the inverse, so stale data cannot pass
  assign dq_i[7:0]  = dq_oe[0] ? dq_o[7:0] : drv ? rd[7:0] : ~rd[7:0];
  assign dq_i[15:8] = dq_oe[1] ? dq_o[15:8] : drv && byte_wide_sel ? rd[15:8] : ~rd[15:8];
  assign status_pin = reset_powerdown_n ? !busy : !abort;
  initial begin
    for (i = 0; i < 16; i = i + 1)
      mem[i] = 16'h5a00 | i[15:0];
  end
  always @* begin
    if (mode_q == 2'h2)
      rd = {8'h00, !busy, 7'h00};
    else if (mode_q == 2'h0)
      rd = mem[wa];
    else if (off < 15'h0002)
      rd = off[0] ? PART_CODE : MAKER_CODE;
    else if (off == 15'h0002)
      rd = {15'h0000, lock_q[flash_addr[15]]};
    else
      rd = 16'h0000;
  end
  always @(negedge we_n) wr_act = sel && oe_n;
  always @(posedge we_n or posedge chip_sel_a_n or posedge chip_sel_b_n) begin
    if (wr_act && !busy) begin
      if (pend_q == 8'h40 && SUPPLY_LOW == 0) begin
        mem[wa] = din;
        busy = 1'b1;
        mode_q = 2'h2;
      end else if (pend_q == 8'h60 && din[7:0] == 8'h01 && SUPPLY_LOW == 0)
        lock_q[flash_addr[15]] = 1'b1;
      else if (din[7:0] == 8'hff)
        mode_q = 2'h0;
      else if (din[7:0] == 8'h90)
        mode_q = 2'h1;
      else if (din[7:0] == 8'h70)
        mode_q = 2'h2;
      pend_q = (pend_q == 8'h00 && din[7:4] inside {4'h4, 4'h6}) ? din[7:0] : 8'h00;
    end
    wr_act = 1'b0;
  end
  always @(posedge busy) begin
    #BUSY_NS;
    busy = 1'b0;
  end
  always @(negedge reset_powerdown_n) begin
    abort = busy;
    busy = 1'b0;
  end
  always @(posedge reset_powerdown_n) begin
    mode_q = 2'h0;
    pend_q = 8'h00;
    abort = 1'b0;
  end
endmodule

// ---- verif/fbc_host_ctrl_assertions.sv ----
// Port assertions for the flash host controller
`timescale 1ns/1ns
module fbc_chk #(
  parameter WAKE_DATA_CYC  = 50,
  parameter WAKE_WRITE_CYC = 50
) (
  // Clock and reset
  input wire       ref_clk,
  input wire       srst,
  // Flash pins
  input wire       chip_sel_a_n,
  input wire       chip_sel_b_n,
  input wire       oe_n,
  input wire       we_n,
  input wire       reset_powerdown_n,
  input wire       byte_wide_sel,
  input wire [1:0] dq_oe
);
  reg [15:0] wake_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Cycles out of power-down, saturating
  always @(posedge ref_clk) begin
    if (srst || !reset_powerdown_n)
      wake_q <= 16'h0000;
    else if (wake_q != 16'hffff)
      wake_q <= wake_q + 16'h0001;
  end
  a_oe_we_excl: assert property (oe_n || we_n)
    else $error("oe_n and we_n low");
  a_read_pins: assert property (!oe_n |-> !chip_sel_a_n && we_n && reset_powerdown_n)
    else $error("read pins wrong");
  a_write_pins: assert property (!we_n |-> oe_n && !chip_sel_a_n && !chip_sel_b_n)
    else $error("write pins wrong");
  a_sel_pair: assert property (chip_sel_a_n == chip_sel_b_n)
    else $error("selects apart");
  a_we_first: assert property ($rose(we_n) |-> !chip_sel_a_n [*2] ##1 chip_sel_a_n)
    else $error("select rose before we_n");
  a_we_pulse: assert property ($fell(we_n) |-> !we_n [*4] ##1 we_n)
    else $error("we_n pulse length");
  a_no_contend: assert property (|dq_oe |-> oe_n)
    else $error("drive during read");
  a_lane_x8: assert property (!byte_wide_sel |-> !dq_oe[1])
    else $error("high lane in x8");
  a_rst_pulse: assert property ($fell(reset_powerdown_n) |-> !reset_powerdown_n [*5])
    else $error("reset pulse short");
  a_pd_idle: assert property (!reset_powerdown_n |-> chip_sel_a_n && oe_n && we_n)
    else $error("access in power-down");
  a_wake_read: assert property ($fell(oe_n) |-> wake_q >= WAKE_DATA_CYC)
    else $error("read before wake");
  a_wake_write: assert property ($fell(we_n) |-> wake_q >= WAKE_WRITE_CYC)
    else $error("write before wake");
  c_read: cover property ($fell(oe_n));
  c_write: cover property ($fell(we_n));
  c_wake: cover property ($rose(reset_powerdown_n));
endmodule
bind fbc_host_ctrl fbc_chk #(
  .WAKE_DATA_CYC (WAKE_DATA_CYC),
  .WAKE_WRITE_CYC(WAKE_WRITE_CYC)
) fbc_chk_i (
  .ref_clk, .srst, .chip_sel_a_n, .chip_sel_b_n, .oe_n, .we_n,
  .reset_powerdown_n, .byte_wide_sel, .dq_oe
);

// ---- verif/tb_fbc_host_ctrl.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
`include "fbc_map.vh"
module tb_fbc_host_ctrl;
  typedef struct packed {
    logic [1:0]  op;
    logic [21:0] a;
    logic [15:0] d;
    logic        wd;
    logic [15:0] e;
  } fbc_row_t;
  localparam [15:0] MAKER = 16'h00a5; // Arbitrary value
  localparam [15:0] PART  = 16'h005c; // Arbitrary value
  reg         ref_clk, srst, clk_en, psel, penable, pwrite, rerr;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdat;
  wire [31:0] prdata;
  wire        pready, pslverr, chip_sel_a_n, chip_sel_b_n, oe_n, we_n;
  wire        reset_powerdown_n, byte_wide_sel, status_pin;
  wire [21:0] flash_addr;
  wire [15:0] dq_i, dq_o;
  wire [1:0]  dq_oe;
  integer     fail_count, checked, r;
  fbc_row_t   rows [0:13];
  fbc_host_ctrl #(.WAKE_DATA_CYC(4), .WAKE_WRITE_CYC(4)) fbc_host_ctrl_i (
    .ref_clk, .srst, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .chip_sel_a_n, .chip_sel_b_n, .oe_n, .we_n, .reset_powerdown_n,
    .byte_wide_sel, .flash_addr, .dq_i, .dq_o, .dq_oe, .status_pin
  );
  fbc_flash_mdl #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fbc_flash_mdl_i (
    .chip_sel_a_n, .chip_sel_b_n, .oe_n, .we_n, .reset_powerdown_n, .byte_wide_sel,
    .flash_addr, .dq_o, .dq_oe, .dq_i, .status_pin
  );
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // The wait ends on pready; if pready never comes, only the watchdog ends it
      do begin
        @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // One flash cycle; rdy also waits for the status pin to show ready
  task fop(input [1:0] op, input [21:0] a, input [15:0] d, input wd, input rdy);
    integer n;
    begin
      apb(`FBC_REG_ADDR, 1'b1, {10'h000, a});
      apb(`FBC_REG_WDATA, 1'b1, {16'h0000, d});
      // Clear a stale done first, such as the one from the reset pulse
      apb(`FBC_REG_STATUS, 1'b1, 32'h4);
      apb(`FBC_REG_CTRL, 1'b1, {28'h0000000, wd, op, 1'b1});
      n = 0;
      do begin
        apb(`FBC_REG_STATUS, 1'b0, 32'h0);
        n = n + 1;
      end while ((rdat[2] !== 1'b1 || (rdy && rdat[1] !== 1'b1)) && n < 300);
      chk("done", 32'h1, {31'h0, rdat[2]});
      apb(`FBC_REG_RDATA, 1'b0, 32'h0);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // The run needs about 15 us
  initial begin
    #600000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    rows = '{
      '{2'h1, 22'h0, 16'h00ff, 1'b1, 16'h0}, '{2'h1, 22'h0, 16'h0040, 1'b1, 16'h0},
      '{2'h1, 22'h3, 16'h1234, 1'b1, 16'h0}, '{2'h1, 22'h0, 16'h00ff, 1'b1, 16'h0},
      '{2'h0, 22'h3, 16'h0000, 1'b1, 16'h1234}, '{2'h0, 22'h3, 16'h0000, 1'b0, 16'h0034},
      '{2'h1, 22'h0, 16'h0090, 1'b1, 16'h0}, '{2'h0, 22'h0, 16'h0000, 1'b1, MAKER},
      '{2'h0, 22'h1, 16'h0000, 1'b1, PART}, '{2'h0, 22'h8002, 16'h0000, 1'b1, 16'h0},
      '{2'h1, 22'h8000, 16'h0060, 1'b1, 16'h0}, '{2'h1, 22'h8000, 16'h0001, 1'b1, 16'h0},
      '{2'h0, 22'h8002, 16'h0000, 1'b1, 16'h1}, '{2'h0, 22'h2, 16'h0000, 1'b1, 16'h0}};
    fail_count = 0;
    checked = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    apb(`FBC_REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", {27'h0, `FBC_CTRL_RST}, rdat);
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    for (r = 0; r < 14; r = r + 1) begin
      fop(rows[r].op, rows[r].a, rows[r].d, rows[r].wd, 1'b1);
      if (rows[r].op === `FBC_OP_READ)
        chk("row data", {16'h0, rows[r].e}, rdat);
    end
    // Program, then reset while the flash is still busy
    fop(`FBC_OP_WRITE, 22'h0, 16'h0040, 1'b1, 1'b1);
    fop(`FBC_OP_WRITE, 22'h5, 16'hbeef, 1'b1, 1'b0);
    apb(`FBC_REG_STATUS, 1'b0, 32'h0);
    chk("busy level", 32'h0, {31'h0, rdat[1]});
    fop(`FBC_OP_RESET, 22'h0, 16'h0, 1'b1, 1'b1);
    fop(`FBC_OP_READ, 22'h3, 16'h0, 1'b1, 1'b1);
    chk("array after wake", 32'h1234, rdat);
    fop(`FBC_OP_WRITE, 22'h0, 16'h0070, 1'b1, 1'b1);
    fop(`FBC_OP_READ, 22'h0, 16'h0, 1'b1, 1'b1);
    chk("status after wake", 32'h80, rdat);
    apb(`FBC_REG_CTRL, 1'b1, 32'h18);
    repeat (10) @(posedge ref_clk);
    apb(`FBC_REG_STATUS, 1'b0, 32'h0);
    chk("power-down flags", 32'ha, rdat & 32'ha);
    apb(`FBC_REG_CTRL, 1'b1, 32'h08);
    fop(`FBC_OP_READ, 22'h3, 16'h0, 1'b0, 1'b1);
    chk("x8 after power-down", 32'h34, rdat);
    // System reset in mid-run also resets the flash
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("flash reset held", 32'h0, {31'h0, reset_powerdown_n});
    apb(`FBC_REG_CTRL, 1'b0, 32'h0);
    chk("ctrl after reset", {27'h0, `FBC_CTRL_RST}, rdat);
    fop(`FBC_OP_READ, 22'h3, 16'h0, 1'b1, 1'b1);
    chk("array after reset", 32'h1234, rdat);
    give_verdict;
  end
endmodule
